// ==== logic/dahp_pkg.sv ====
// ==========================================================================
// Shared constants of the dual result line serial host port
package dahp_pkg;

  // ========================================================================
  // Register map, byte addresses on the AXI4-Lite slave
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;  // Enable, word length, power-down
  localparam logic [7:0]  ADDR_DIV      = 8'h04;  // Serial clock half period
  localparam logic [7:0]  ADDR_INTERVAL = 8'h08;  // Sample interval in clock periods
  localparam logic [7:0]  ADDR_STATUS   = 8'h0C;  // Busy, sticky miss flag, burst pending, fill level
  localparam logic [7:0]  ADDR_DATA     = 8'h10;  // Pops one result pair

  // ========================================================================
  // Field positions
  localparam int CTRL_EN_BIT     = 0;   // Sample timer and frames enabled
  localparam int CTRL_LEN16_BIT  = 1;   // 1: 16 clock frame, 0: 14 clock frame
  localparam int CTRL_PD_BIT     = 2;   // Write 1: next frame is a power-down burst
  localparam int STAT_BUSY_BIT   = 0;   // Frame in progress
  localparam int STAT_MISS_BIT   = 1;   // Sticky, write 1 to clear
  localparam int STAT_PD_BIT     = 2;   // Power-down burst pending
  localparam int STAT_CNT_LSB    = 8;   // FIFO fill level
  localparam int STAT_CNT_MSB    = 12;
  localparam int HALF_W          = 16;  // Result word B sits above this position

  // ========================================================================
  // Reset values
  localparam logic [1:0]  CTRL_RST      = 2'h2;    // Disabled, 16 clock frames
  localparam logic [7:0]  DIV_RST       = 8'h04;   // 8 clk per serial clock period
  localparam logic [7:0]  DIV_MIN       = 8'h03;   // Input synchroniser needs 3 clk
  localparam logic [15:0] INTERVAL_RST  = 16'h0020;

  // ========================================================================
  // Frame lengths in serial clock cycles
  localparam logic [4:0]  BITS_LONG     = 5'h10;
  localparam logic [4:0]  BITS_SHORT    = 5'h0E;
  localparam logic [4:0]  BITS_PD       = 5'h08;

  // ========================================================================
  // Buffering and bus answers
  localparam int          FIFO_W        = 32;
  localparam int          FIFO_DEPTH    = 16;
  localparam int          CNT_W         = 5;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // Frame sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WAIT  = 4'h2,
    ST_FRAME = 4'h4,
    ST_GAP   = 4'h8
  } dahp_state_type;

endpackage

// ==== logic/dahp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Result FIFO, registered storage, valid and ready on both sides
module dahp_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [W-1:0]               in_data,
  input  wire logic                       in_valid,
  output logic                            in_ready,
  output logic [W-1:0]                    out_data,
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output logic [$clog2(DEPTH):0]          count
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];    // Storage array
  logic [AW:0]   wr_ptr_r;       // Extra bit tells full from empty
  logic [AW:0]   rd_ptr_r;
  wire           push;
  wire           pop;

  assign count     = wr_ptr_r - rd_ptr_r;
  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr_r[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // ========================================================================
  // Pointers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end

  // Storage has no reset, so it maps to plain memory
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data;
    end
  end

endmodule
`default_nettype wire

// ==== logic/dahp_host.sv ====
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dahp_host (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [dahp_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [31:0]                 s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [dahp_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [31:0]                      s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  output logic                             serial_clock,
  output logic                             transmit_frame_sync_n,
  input  wire logic                        result_line_a,
  input  wire logic                        result_line_b
);

  // ========================================================================
  // Declarations
  dahp_pkg::dahp_state_type state_r;          // Frame sequencer
  logic [1:0]                ctrl_r;           // Enable and word length
  logic [7:0]                div_r;            // Half period in clk cycles
  logic [15:0]               interval_r;       // Serial clock periods per sample
  logic                      missed_r;         // Sticky: trigger found no room or a frame in progress
  logic                      pd_pend_r;        // Power-down burst requested
  logic [7:0]                div_cnt_r;        // Divider down counter
  logic                      sclk_r;           // Serial clock level
  logic                      cs_n_r;           // Chip-select level
  logic [15:0]               tmr_r;            // Sample timer
  logic                      seen_fall_r;      // Clock went low since request
  logic                      pd_frame_r;       // Current frame is a burst
  logic [4:0]                nbits_r;          // Clocks in current frame
  logic [4:0]                fcnt_r;           // Falling edges in frame
  logic [15:0]               sh_a_r;           // Word from line A
  logic [15:0]               sh_b_r;           // Word from line B
  logic                      a_s1_r, a_s2_r;   // Line A synchroniser
  logic                      b_s1_r, b_s2_r;   // Line B synchroniser
  logic [dahp_pkg::ADDR_W-1:0] awaddr_r;       // Held write address
  logic                      aw_held_r;
  logic [31:0]               wdata_r;          // Held write data
  logic [3:0]                wstrb_r;
  logic                      w_held_r;
  logic                      bvalid_r;
  logic [1:0]                bresp_r;
  logic                      rvalid_r;
  logic [31:0]               rdata_r;
  logic [1:0]                rresp_r;
  logic [dahp_pkg::CNT_W-1:0] fifo_cnt;
  logic [31:0]               fifo_out;
  logic                      fifo_out_valid;
  logic                      fifo_in_ready;
  logic                      pop;              // A data read takes one entry

  // ========================================================================
  // Serial clock divider and edge events
  wire [7:0]  div_eff  = (div_r < dahp_pkg::DIV_MIN) ? dahp_pkg::DIV_MIN : div_r;
  wire        tick     = (div_cnt_r == 8'h00);
  wire        rise_ev  = tick & ~sclk_r;   // Clock goes high next cycle
  wire        fall_ev  = tick & sclk_r;    // Clock goes low next cycle
  wire [7:0]  div_nxt  = tick ? (div_eff - 8'h01) : (div_cnt_r - 8'h01);

  // Clock runs free from reset on; frames are cut out of it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= 8'h00;
      sclk_r    <= 1'b0;
    end else begin
      div_cnt_r <= div_nxt;
      sclk_r    <= sclk_r ^ tick;
    end
  end

  // ========================================================================
  // Sample timer, counts whole clock periods only
  wire        en          = ctrl_r[dahp_pkg::CTRL_EN_BIT];
  wire [15:0] interval_m1 = interval_r - 16'h0001;
  wire        tmr_wrap    = (tmr_r == interval_m1);
  wire        trig        = en & rise_ev & tmr_wrap;
  wire [15:0] tmr_nxt     = !en ? 16'h0000 :
                            !rise_ev ? tmr_r :
                            tmr_wrap ? 16'h0000 : tmr_r + 16'h0001;

  // Stepping only on rising events keeps triggers on one clock phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_r <= 16'h0000;
    end else begin
      tmr_r <= tmr_nxt;
    end
  end

  // ========================================================================
  // Result line synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      a_s1_r <= 1'b0;
      a_s2_r <= 1'b0;
      b_s1_r <= 1'b0;
      b_s2_r <= 1'b0;
    end else begin
      a_s1_r <= result_line_a;
      a_s2_r <= a_s1_r;
      b_s1_r <= result_line_b;
      b_s2_r <= b_s1_r;
    end
  end

  // ========================================================================
  // Frame sequencer decode
  wire in_idle   = (state_r == dahp_pkg::ST_IDLE);
  wire in_wait   = (state_r == dahp_pkg::ST_WAIT);
  wire in_frame  = (state_r == dahp_pkg::ST_FRAME);
  wire in_gap    = (state_r == dahp_pkg::ST_GAP);
  wire start     = trig & in_idle & fifo_in_ready;  // A full FIFO stalls sampling
  wire miss_ev   = trig & ~start;
  wire go_low    = in_wait & rise_ev & seen_fall_r;
  wire shift_ev  = in_frame & fall_ev;
  wire frame_end = in_frame & rise_ev & (fcnt_r == nbits_r);
  wire push      = frame_end & ~pd_frame_r;
  wire [4:0] len_sel = pd_pend_r ? dahp_pkg::BITS_PD :
                       ctrl_r[dahp_pkg::CTRL_LEN16_BIT] ? dahp_pkg::BITS_LONG :
                       dahp_pkg::BITS_SHORT;
  wire [31:0] push_data = {sh_b_r, sh_a_r};

  // State and chip-select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= dahp_pkg::ST_IDLE;
      cs_n_r  <= 1'b1;
    end else begin
      case (state_r)
        dahp_pkg::ST_IDLE: begin
          if (start) begin
            state_r <= dahp_pkg::ST_WAIT;
          end
        end
        dahp_pkg::ST_WAIT: begin
          if (go_low) begin
            state_r <= dahp_pkg::ST_FRAME;
            cs_n_r  <= 1'b0;
          end
        end
        dahp_pkg::ST_FRAME: begin
          if (frame_end) begin
            state_r <= dahp_pkg::ST_GAP;
            cs_n_r  <= 1'b1;
          end
        end
        dahp_pkg::ST_GAP: begin
          if (rise_ev) begin
            state_r <= dahp_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= dahp_pkg::ST_IDLE;
          cs_n_r  <= 1'b1;
        end
      endcase
    end
  end

  // Frame bookkeeping, latched when the request is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seen_fall_r <= 1'b0;
      pd_frame_r  <= 1'b0;
      nbits_r     <= dahp_pkg::BITS_LONG;
      fcnt_r      <= 5'h00;
    end else if (start) begin
      seen_fall_r <= 1'b0;
      pd_frame_r  <= pd_pend_r;
      nbits_r     <= len_sel;
      fcnt_r      <= 5'h00;
    end else begin
      seen_fall_r <= seen_fall_r | (in_wait & fall_ev);
      fcnt_r      <= fcnt_r + 5'(shift_ev);
    end
  end

  // Both lines shift together on the falling event, MSB first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_a_r <= 16'h0000;
      sh_b_r <= 16'h0000;
    end else if (start) begin
      sh_a_r <= 16'h0000;
      sh_b_r <= 16'h0000;
    end else if (shift_ev) begin
      sh_a_r <= {sh_a_r[14:0], a_s2_r};
      sh_b_r <= {sh_b_r[14:0], b_s2_r};
    end
  end

  // ========================================================================
  // Result FIFO
  dahp_fifo #(
    .W     (dahp_pkg::FIFO_W),
    .DEPTH (dahp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_data   (push_data),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .count     (fifo_cnt)
  );

  // ========================================================================
  // AXI4-Lite write path; address and data may come in either order
  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire do_wr   = aw_held_r & w_held_r & ~bvalid_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire wr_ctrl = do_wr & (awaddr_r == dahp_pkg::ADDR_CTRL);
  wire wr_div  = do_wr & (awaddr_r == dahp_pkg::ADDR_DIV);
  wire wr_int  = do_wr & (awaddr_r == dahp_pkg::ADDR_INTERVAL);
  wire wr_stat = do_wr & (awaddr_r == dahp_pkg::ADDR_STATUS);
  wire wr_ok   = wr_ctrl | wr_div | wr_int | wr_stat |
                 (do_wr & (awaddr_r == dahp_pkg::ADDR_DATA));
  wire [31:0] ctrl_m = ({30'h0, ctrl_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] div_m  = ({24'h0, div_r} & ~wmask) | (wdata_r & wmask);
  wire [31:0] int_m  = ({16'h0, interval_r} & ~wmask) | (wdata_r & wmask);
  wire pd_set  = wr_ctrl & wstrb_r[0] & wdata_r[dahp_pkg::CTRL_PD_BIT];
  wire miss_clr = wr_stat & wstrb_r[0] & wdata_r[dahp_pkg::STAT_MISS_BIT];

  assign s_axi_awready = ~aw_held_r & ~bvalid_r;
  assign s_axi_wready  = ~w_held_r & ~bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  // Channel holding and response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= dahp_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_ok ? dahp_pkg::RESP_OKAY : dahp_pkg::RESP_DECERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Control registers; hardware set wins over a software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r     <= dahp_pkg::CTRL_RST;
      div_r      <= dahp_pkg::DIV_RST;
      interval_r <= dahp_pkg::INTERVAL_RST;
      pd_pend_r  <= 1'b0;
      missed_r   <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= ctrl_m[1:0];
      end
      if (wr_div) begin
        div_r <= div_m[7:0];
      end
      if (wr_int) begin
        interval_r <= int_m[15:0];
      end
      pd_pend_r <= pd_set | (pd_pend_r & ~start);
      missed_r  <= miss_ev | (missed_r & ~miss_clr);
    end
  end

  // ========================================================================
  // AXI4-Lite read path; a read of the data word pops the FIFO
  wire ar_hs   = s_axi_arvalid & s_axi_arready;
  wire rd_data = (s_axi_araddr == dahp_pkg::ADDR_DATA);
  assign pop   = ar_hs & rd_data & fifo_out_valid;
  wire [31:0] stat_word = {19'h0, fifo_cnt, 5'h0, pd_pend_r, missed_r, ~in_idle};
  wire [31:0] rd_mux = (s_axi_araddr == dahp_pkg::ADDR_CTRL)     ? {30'h0, ctrl_r} :
                       (s_axi_araddr == dahp_pkg::ADDR_DIV)      ? {24'h0, div_r} :
                       (s_axi_araddr == dahp_pkg::ADDR_INTERVAL) ? {16'h0, interval_r} :
                       (s_axi_araddr == dahp_pkg::ADDR_STATUS)   ? stat_word :
                       (rd_data & fifo_out_valid)                ? fifo_out : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr == dahp_pkg::ADDR_CTRL) | (s_axi_araddr == dahp_pkg::ADDR_DIV) |
               (s_axi_araddr == dahp_pkg::ADDR_INTERVAL) |
               (s_axi_araddr == dahp_pkg::ADDR_STATUS) | rd_data;

  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      rresp_r  <= dahp_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_r <= 1'b1;
      rdata_r  <= rd_mux;
      rresp_r  <= rd_ok ? dahp_pkg::RESP_OKAY : dahp_pkg::RESP_DECERR;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  assign serial_clock          = sclk_r;
  assign transmit_frame_sync_n = cs_n_r;

  // ========================================================================
  // Checks: cycles chip-select has been high, for the gap check
  logic [15:0] cs_high_cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_high_cnt_r <= 16'h0000;
    end else if (!cs_n_r) begin
      cs_high_cnt_r <= 16'h0000;
    end else if (cs_high_cnt_r != 16'hFFFF) begin
      cs_high_cnt_r <= cs_high_cnt_r + 16'h0001;
    end
  end

  property p_cs_on_rise;
    @(posedge clk) disable iff (rst) $fell(cs_n_r) |-> $rose(sclk_r);
  endproperty
  a_cs_on_rise: assert property (p_cs_on_rise) else $error("frame start off rise");

  property p_frame_len;
    @(posedge clk) disable iff (rst) $rose(cs_n_r) |->
      ($past(fcnt_r) == dahp_pkg::BITS_LONG) || ($past(fcnt_r) == dahp_pkg::BITS_SHORT) ||
      ($past(fcnt_r) == dahp_pkg::BITS_PD);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("bad frame length");

  property p_pd_len;
    @(posedge clk) disable iff (rst) (frame_end && pd_frame_r) |->
      (fcnt_r == dahp_pkg::BITS_PD) && !push;
  endproperty
  a_pd_len: assert property (p_pd_len) else $error("burst wrong or stored");

  property p_gap;
    @(posedge clk) disable iff (rst) $fell(cs_n_r) |->
      ($past(cs_high_cnt_r) >= {7'h00, div_eff, 1'b0});
  endproperty
  a_gap: assert property (p_gap) else $error("chip-select gap too short");

  property p_div_step;
    @(posedge clk) disable iff (rst) $changed(sclk_r) |-> ($past(div_cnt_r) == 8'h00);
  endproperty
  a_div_step: assert property (p_div_step) else $error("clock edge off divider");

  property p_start_seq;
    @(posedge clk) disable iff (rst) $fell(cs_n_r) |->
      $past(in_wait) && $past(seen_fall_r) && $past(sclk_r, 2) == 1'b0;
  endproperty
  a_start_seq: assert property (p_start_seq) else $error("frame started early");

  property p_trigger;
    @(posedge clk) disable iff (rst) start |=> in_wait ##1 (!cs_n_r || in_wait) [*2];
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger lost");

  property p_missed;
    @(posedge clk) disable iff (rst) (trig && !fifo_in_ready) |=> missed_r && in_idle;
  endproperty
  a_missed: assert property (p_missed) else $error("stall not flagged");

  property p_timer_phase;
    @(posedge clk) disable iff (rst) (en && $changed(tmr_r)) |-> $past(rise_ev) || !$past(en);
  endproperty
  a_timer_phase: assert property (p_timer_phase) else $error("timer off phase");

  property p_push_data;
    @(posedge clk) disable iff (rst) push |-> (nbits_r != dahp_pkg::BITS_PD) &&
      ((nbits_r == dahp_pkg::BITS_LONG) || (sh_a_r[15:14] == 2'h0 && sh_b_r[15:14] == 2'h0));
  endproperty
  a_push_data: assert property (p_push_data) else $error("word not right justified");

  c_normal: cover property (@(posedge clk) disable iff (rst) push);
  c_pd:     cover property (@(posedge clk) disable iff (rst) frame_end && pd_frame_r);
  c_miss:   cover property (@(posedge clk) disable iff (rst) miss_ev);
  c_pop:    cover property (@(posedge clk) disable iff (rst) pop);

endmodule
`default_nettype wire

// ==== dv/dahp_adc_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// Dual result line converter: both results shift out on serial clock falls
module dahp_adc_model #(
  parameter logic [11:0] VAL_A = 12'h000,
  parameter logic [11:0] VAL_B = 12'h000
) (
  input  wire logic clk,
  input  wire logic serial_clock,
  input  wire logic cs_n,
  output wire logic line_a,
  output wire logic line_b
);
  logic [31:0] sh_a, sh_b;   // Own result, then the other channel's
  logic        junk = 1'b0;  // Released lines toggle, no pull on them
  logic        pd_r = 1'b0;  // Sticky: power-down entered by an early rise
  int          falls = 0;    // Falls seen in this frame
  // Fall of chip-select samples: two lead zeros, 12 bits, two trailing zeros
  always @(negedge cs_n) begin
    sh_a = {2'b00, VAL_A, 4'h0, VAL_B, 2'b00};
    sh_b = {2'b00, VAL_B, 4'h0, VAL_A, 2'b00};
    falls = 0;
  end
  // Each fall moves on one bit; even a long frame stops short of the other result
  always @(negedge serial_clock) if (!cs_n) begin
    sh_a = sh_a << 1;
    sh_b = sh_b << 1;
    falls = falls + 1;
  end
  // Rise before the conversion is done powers down
  // A rise out of reset has no falls behind it and is not a frame
  always @(posedge cs_n) pd_r = pd_r | (falls > 0 && falls < 14);
  always @(posedge clk) junk <= ~junk;
  assign line_a = cs_n ? junk : sh_a[31];
  assign line_b = cs_n ? ~junk : sh_b[31];
endmodule
`default_nettype wire

// ==== dv/dahp_host_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench: AXI4-Lite tasks, converter model, frame monitor
module dahp_host_tb_top;
  localparam logic [11:0] VA = 12'hA5C;  // Distinct patterns per line
  localparam logic [11:0] VB = 12'h3C6;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  bresp, rresp;
  logic        awr, wr_, bv, arr, rv, sclk, cs_n, la, lb, sclk_q = 1'b0, cs_q = 1'b1;
  int          errors = 0, comparisons = 0, cyc = 0, lastf = 0, ivl = 0, falls = 0;
  int          q[$];  // Length of each finished frame in falls
  always #20 clk = ~clk;
  dahp_host u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .serial_clock(sclk),
    .transmit_frame_sync_n(cs_n), .result_line_a(la), .result_line_b(lb));
  dahp_adc_model #(.VAL_A(VA), .VAL_B(VB)) u_adc (.clk(clk), .serial_clock(sclk),
    .cs_n(cs_n), .line_a(la), .line_b(lb));
  // Monitor: falls per frame and spacing of frame starts in clk cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sclk_q <= sclk;
    cs_q <= cs_n;
    if (!cs_n && sclk_q && !sclk) falls <= falls + 1;
    if (cs_q && !cs_n) begin
      ivl <= cyc - lastf;
      lastf <= cyc;
      falls <= 0;
    end
    if (!cs_q && cs_n) q.push_back(falls);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic at, wt;
    at = 1'b0;
    wt = 1'b0;
    @(posedge clk);
    {awa, wd, awv, wv, br} <= {a, d, 3'b111};
    while (!(at && wt)) begin
      @(posedge clk);
      if (!at && awr) begin
        at = 1'b1;
        awv <= 1'b0;
      end
      if (!wt && wr_) begin
        wt = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bv !== 1'b1) @(posedge clk);
    br <= 1'b0;
    chk({30'h0, bresp}, 32'h0, "bresp");
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] re);
    @(posedge clk);
    {ara, arv, rr} <= {a, 2'b11};
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    rr <= 1'b0;
    chk({30'h0, rresp}, {30'h0, re}, "rresp");
    if (re == 2'h0) chk(rdat, exp, "rdata");
  endtask
  // One run in a mode, stop, then check status and drain the FIFO
  task automatic run(input logic [31:0] c, input int n, input int len, input logic [31:0] d,
                     input logic m);
    int pushed;
    q.delete();
    wr(8'h00, c);
    while (q.size() < n) @(posedge clk);
    repeat (400) @(posedge clk);
    wr(8'h00, 32'h2);
    repeat (400) @(posedge clk);
    pushed = c[2] ? q.size() - 1 : q.size();
    chk(q[0], len, "frame length");
    chk(ivl, 200, "frame spacing");
    rd(8'h0C, (pushed << 8) | (m << 1), 2'h0);
    chk({31'h0, u_adc.pd_r}, {31'h0, c[2]}, "power-down entered");
    for (int i = 0; i < pushed; i++) rd(8'h10, d, 2'h0);
    rd(8'h10, 32'h0, 2'h0);
  endtask
  task automatic finish_test();
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h2, 2'h0);
    rd(8'h04, 32'h4, 2'h0);
    rd(8'h08, 32'h20, 2'h0);
    rd(8'h14, 32'h0, 2'h3);
    wr(8'h04, 32'h5);
    wr(8'h08, 32'h14);
    run(32'h3, 16, 16, {2'b00, VB, 4'h0, VA, 2'b00}, 1'b1);
    wr(8'h0C, 32'h2);
    rd(8'h0C, 32'h0, 2'h0);
    run(32'h1, 2, 14, {4'h0, VB, 4'h0, VA}, 1'b0);
    run(32'h7, 3, 8, {2'b00, VB, 4'h0, VA, 2'b00}, 1'b0);
    finish_test();
  end
  // Watchdog well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
